// file: design/glyph_pkg.sv
/*
 * constants of the user glyph text attribute block: register map,
 * attribute field positions, glyph geometry, render states.
 * assumes a 20 MHz core clock and an axi4-lite register master.
 */
package glyph_pkg;
    // attribute register index; its word sits at four times the index
    localparam logic [7:0] idx_attr      = 8'hcd;
    // register byte addresses
    localparam logic [9:0] off_attr      = {idx_attr, 2'b00}; // attribute
    localparam logic [9:0] off_base      = 10'h000; // glyph ram base
    localparam logic [9:0] off_ctrl      = 10'h004; // size, vertical_scan_direction, start
    localparam logic [9:0] off_code      = 10'h008; // glyph code
    localparam logic [9:0] off_status    = 10'h00c; // busy, address
    localparam logic [9:0] off_pos       = 10'h010; // pen x/y
    // attribute field positions
    localparam int attr_wscale_lo = 0;  // width factor field
    localparam int attr_hscale_lo = 2;  // height factor field
    localparam int attr_rotate    = 4;
    localparam int attr_transp    = 6;
    localparam int attr_align     = 7;
    // control field positions
    localparam int ctrl_size_lo   = 0;  // 3-bit glyph size
    localparam int ctrl_vertical_scan_direction      = 3;
    localparam int ctrl_start     = 8;
    // reset values
    localparam logic [7:0]  attr_reset = 8'h00;
    localparam logic [31:0] base_reset = 32'h0000_0000;
    localparam logic [3:0]  ctrl_reset = 4'h0;
    // glyph sizes
    typedef enum logic [2:0] {
        size_8x16  = 3'h0,
        size_16x16 = 3'h1,
        size_12x24 = 3'h2,
        size_24x24 = 3'h3,
        size_16x32 = 3'h4,
        size_32x32 = 3'h5
    } glyph_size_t;
    // render states
    typedef enum logic [1:0] {
        st_idle  = 2'h0,
        st_fetch = 2'h1,
        st_wait  = 2'h2,
        st_pix   = 2'h3
    } render_state_t;
    localparam logic [15:0] full_width_code = 16'h8000;

    // byte count for a glyph size
    function automatic logic [7:0] glyph_bytes(input logic [2:0] s);
        case (s)
            size_8x16:  glyph_bytes = 8'd16;
            size_16x16: glyph_bytes = 8'd32;
            size_12x24: glyph_bytes = 8'd48;
            size_24x24: glyph_bytes = 8'd72;
            size_16x32: glyph_bytes = 8'd64;
            size_32x32: glyph_bytes = 8'd128;
            default:    glyph_bytes = 8'd16;
        endcase
    endfunction

    // glyph width in pixels
    function automatic logic [5:0] glyph_w(input logic [2:0] s);
        case (s)
            size_8x16:  glyph_w = 6'd8;
            size_12x24: glyph_w = 6'd12;
            size_16x16, size_16x32: glyph_w = 6'd16;
            size_24x24: glyph_w = 6'd24;
            default:    glyph_w = 6'd32;
        endcase
    endfunction

    // glyph height in pixels
    function automatic logic [5:0] glyph_h(input logic [2:0] s);
        case (s)
            size_8x16, size_16x16: glyph_h = 6'd16;
            size_12x24, size_24x24: glyph_h = 6'd24;
            default: glyph_h = 6'd32;
        endcase
    endfunction

    // byte addresses that answer on the register bus
    function automatic logic reg_mapped(input logic [9:0] a);
        reg_mapped = a == off_attr || a == off_base || a == off_ctrl
            || a == off_code || a == off_status || a == off_pos;
    endfunction
endpackage

// file: design/glyph_byte_reg.sv
/*
 * one-byte read register for fetched glyph data; holds the latest byte.
 * assumes memory data is valid in the cycle mem_rvalid is high.
 */
`timescale 1ns/1ns
`default_nettype none
module glyph_byte_reg (
    input  wire logic       core_clk,   // core clock
    input  wire logic       rstn,       // async reset, low
    input  wire logic       load,       // capture strobe
    input  wire logic [7:0] din,        // memory byte
    input  wire logic       odd_mask,   // drop low nibble
    output logic      [7:0] dout        // registered byte
);
    // capture byte, masking low nibble when asked
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            dout <= 8'h00;
        end else if (load) begin
            dout <= odd_mask ? {din[7:4], 4'h0} : din;
        end
    end
endmodule
`default_nettype wire

// file: design/glyph_text_attr.sv
/*
 * user glyph renderer with text attributes: resolves the glyph code into
 * a display memory address, fetches bytes, emits enlarged pixels.
 * assumes a single-cycle-latency byte memory and an axi4-lite master.
 */
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module glyph_text_attr (
    input  wire logic        core_clk,      // 20 MHz core clock
    input  wire logic        rstn,          // async reset, low
    input  wire logic [9:0]  s_awaddr,      // axi write address
    input  wire logic        s_awvalid,
    output logic             s_awready,
    input  wire logic [31:0] s_wdata,
    input  wire logic [3:0]  s_wstrb,
    input  wire logic        s_wvalid,
    output logic             s_wready,
    output logic [1:0]       s_bresp,
    output logic             s_bvalid,
    input  wire logic        s_bready,
    input  wire logic [9:0]  s_araddr,
    input  wire logic        s_arvalid,
    output logic             s_arready,
    output logic [31:0]      s_rdata,
    output logic [1:0]       s_rresp,
    output logic             s_rvalid,
    input  wire logic        s_rready,
    output logic [31:0]      mem_addr,      // glyph byte address
    output logic             mem_req,       // read request pulse
    input  wire logic        mem_rvalid,    // byte returned
    input  wire logic [7:0]  mem_rdata,
    output logic [15:0]      pix_x,         // pixel target x
    output logic [15:0]      pix_y,         // pixel target y
    output logic             pix_fg,        // 1 foreground, 0 background
    output logic             pix_we,        // pixel write strobe
    output logic             text_cursor_en,     // cursor allowed
    output logic             graphic_cursor_en,
    output logic             overlay_window_en
);
    import glyph_pkg::*;

    // software state
    logic [7:0]  attr;          // attribute control
    logic [31:0] glyph_ram_base;
    logic [3:0]  ctrl;          // size and vertical scan direction
    logic [15:0] glyph_code;
    logic [15:0] pen_x, pen_y;  // text pen
    logic        start;         // render kick pulse
    // render state
    render_state_t state;
    logic [6:0]  byte_idx;      // byte within glyph
    logic [2:0]  bit_idx;       // pixel within byte
    logic [5:0]  row, col;      // glyph row, column
    logic [1:0]  sx, sy;        // enlargement repeat counters
    logic [7:0]  cur_byte;
    logic [31:0] glyph_address;

    // size used: bit 0 of each half/full size pair follows the code width
    logic [2:0] size_sel;
    logic       code_full;
    assign code_full = glyph_code >= full_width_code;
    always_comb begin
        size_sel = ctrl[2:0];
        if (ctrl[2:0] <= size_32x32)
            size_sel = {ctrl[2:1], code_full};
    end
    // absolute glyph address from base and code
    assign glyph_address = glyph_ram_base
        + 32'(glyph_code) * 32'(glyph_bytes(size_sel));

    logic [5:0] gw, gh;
    logic [1:0] wscale, hscale;
    assign gw = glyph_w(size_sel);
    assign gh = glyph_h(size_sel);
    assign wscale = attr[attr_wscale_lo +: 2];
    assign hscale = attr[attr_hscale_lo +: 2];

    // cursors and overlay disabled while vertical scan direction is set
    assign text_cursor_en    = !ctrl[ctrl_vertical_scan_direction];
    assign graphic_cursor_en = !ctrl[ctrl_vertical_scan_direction];
    assign overlay_window_en = !ctrl[ctrl_vertical_scan_direction];

    // axi write channel: take address and data in either order
    logic        aw_held, w_held;
    logic [9:0]  aw_q;
    logic [31:0] w_q;
    logic [3:0]  strb_q;
    logic        do_write;
    assign s_awready = !aw_held && !s_bvalid;
    assign s_wready  = !w_held && !s_bvalid;
    assign do_write  = aw_held && w_held;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_q    <= 10'h000;
            w_q     <= 32'h0000_0000;
            strb_q  <= 4'h0;
            s_bvalid <= 1'b0;
            s_bresp  <= 2'h0;
        end else begin
            if (s_awvalid && s_awready) begin
                aw_held <= 1'b1;
                aw_q    <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
                w_held <= 1'b1;
                w_q    <= s_wdata;
                strb_q <= s_wstrb;
            end
            if (do_write) begin
                aw_held  <= 1'b0;
                w_held   <= 1'b0;
                s_bvalid <= 1'b1;
                s_bresp  <= reg_mapped(aw_q) ? 2'h0 : 2'h2; // slverr off map
            end else if (s_bvalid && s_bready) begin
                s_bvalid <= 1'b0;
            end
        end
    end

    // register stores from completed writes
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            attr           <= attr_reset;
            glyph_ram_base <= base_reset;
            ctrl           <= ctrl_reset;
            glyph_code     <= 16'h0000;
            start          <= 1'b0;
        end else begin
            start <= 1'b0;
            if (do_write) begin
                case (aw_q)
                    off_attr: if (strb_q[0]) attr <= w_q[7:0];
                    off_base: begin
                        for (int i = 0; i < 4; i++)
                            if (strb_q[i])
                                glyph_ram_base[8*i +: 8] <= w_q[8*i +: 8];
                    end
                    off_ctrl: begin
                        if (strb_q[0]) ctrl <= w_q[3:0];
                        // start accepted only when idle
                        if (strb_q[1] && w_q[ctrl_start] && state == st_idle)
                            start <= 1'b1;
                    end
                    off_code: begin
                        if (strb_q[0]) glyph_code[7:0]  <= w_q[7:0];
                        if (strb_q[1]) glyph_code[15:8] <= w_q[15:8];
                    end
                    default: ;
                endcase
            end
        end
    end

    // axi read channel, one cycle after address
    assign s_arready = !s_rvalid;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s_rvalid <= 1'b0;
            s_rdata  <= 32'h0000_0000;
            s_rresp  <= 2'h0;
        end else if (s_arvalid && s_arready) begin
            s_rvalid <= 1'b1;
            s_rresp  <= 2'h0;
            case (s_araddr)
                off_attr:   s_rdata <= {24'h0, attr};
                off_base:   s_rdata <= glyph_ram_base;
                off_ctrl:   s_rdata <= {28'h0, ctrl};
                off_code:   s_rdata <= {16'h0, glyph_code};
                off_status: s_rdata <= {glyph_address[30:0], state != st_idle};
                off_pos:    s_rdata <= {pen_y, pen_x};
                default: begin
                    s_rdata <= 32'h0000_0000;
                    s_rresp <= 2'h2;
                end
            endcase
        end else if (s_rready) begin
            s_rvalid <= 1'b0;
        end
    end

    // odd byte of a 12x24 glyph loses its low nibble
    glyph_byte_reg u_byte (
        .core_clk (core_clk),
        .rstn     (rstn),
        .load     (state == st_wait && mem_rvalid),
        .din      (mem_rdata),
        .odd_mask (size_sel == size_12x24 && byte_idx[0]),
        .dout     (cur_byte)
    );

    // last pixel of current byte inside glyph width; row and glyph end
    logic last_px, row_done, glyph_done;
    assign last_px   = (bit_idx == 3'd7) || (col + 6'd1 == gw);
    assign row_done  = (col + 6'd1 == gw) && (sx == wscale);
    assign glyph_done = row_done && (row + 6'd1 == gh) && (sy == hscale);

    // fetch and render sequence
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state    <= st_idle;
            byte_idx <= 7'h00;
            bit_idx  <= 3'h0;
            row <= 6'h00;
            col <= 6'h00;
            sx  <= 2'h0;
            sy  <= 2'h0;
        end else begin
            case (state)
                st_idle: if (start) begin
                    state <= st_fetch;
                    byte_idx <= 7'h00;
                    bit_idx <= 3'h0;
                    row <= 6'h00;
                    col <= 6'h00;
                    sx  <= 2'h0;
                    sy  <= 2'h0;
                end
                st_fetch: state <= st_wait;
                st_wait:  if (mem_rvalid) state <= st_pix;
                st_pix: begin
                    if (sx != wscale) begin
                        sx <= sx + 2'd1;
                    end else begin
                        sx <= 2'h0;
                        if (glyph_done) begin
                            state <= st_idle;
                        end else if (row_done) begin
                            col <= 6'h00;
                            bit_idx <= 3'h0;
                            if (sy != hscale) begin
                                sy <= sy + 2'd1;
                                // refetch row start for repeat
                                byte_idx <= byte_idx - 7'(gw[5:3]
                                    + {5'h0, |gw[2:0]}) + 7'd1;
                            end else begin
                                sy  <= 2'h0;
                                row <= row + 6'd1;
                                byte_idx <= byte_idx + 7'd1;
                            end
                            state <= st_fetch;
                        end else if (last_px) begin
                            col <= col + 6'd1;
                            bit_idx <= 3'h0;
                            byte_idx <= byte_idx + 7'd1;
                            state <= st_fetch;
                        end else begin
                            col <= col + 6'd1;
                            bit_idx <= bit_idx + 3'd1;
                        end
                    end
                end
                default: state <= st_idle;
            endcase
        end
    end

    assign mem_req  = (state == st_fetch);
    assign mem_addr = glyph_address + 32'(byte_idx);

    // target position; rotation swaps axes of glyph and advance
    logic [15:0] off_x, off_y;
    assign off_x = 16'(col) * 16'({1'b0, wscale} + 3'd1) + 16'(sx);
    assign off_y = 16'(row) * 16'({1'b0, hscale} + 3'd1) + 16'(sy);
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pix_x  <= 16'h0000;
            pix_y  <= 16'h0000;
            pix_fg <= 1'b0;
            pix_we <= 1'b0;
        end else begin
            pix_x  <= attr[attr_rotate] ? pen_x + off_y : pen_x + off_x;
            pix_y  <= attr[attr_rotate] ? pen_y + off_x : pen_y + off_y;
            pix_fg <= cur_byte[3'd7 - bit_idx];
            // background skipped in transparent mode
            pix_we <= state == st_pix && (cur_byte[3'd7 - bit_idx]
                || !attr[attr_transp]);
        end
    end

    // pen advance after a glyph; aligned mode uses full-width cell
    logic [15:0] adv_w, adv_h;
    assign adv_w = 16'(attr[attr_align] && !code_full ? gw << 1 : {1'b0, gw})
        * 16'({1'b0, wscale} + 3'd1);
    assign adv_h = 16'(gh) * 16'({1'b0, hscale} + 3'd1);
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pen_x <= 16'h0000;
            pen_y <= 16'h0000;
        end else if (do_write && aw_q == off_pos) begin
            pen_x <= w_q[15:0];
            pen_y <= w_q[31:16];
        end else if (state == st_pix && sx == wscale && glyph_done) begin
            if (attr[attr_rotate])
                pen_y <= pen_y + adv_w;
            else
                pen_x <= pen_x + adv_w;
        end
    end

    // checks
    a_cursor_off: assert property (@(posedge core_clk)
        disable iff (!rstn) ctrl[ctrl_vertical_scan_direction] |-> !text_cursor_en
            && !graphic_cursor_en && !overlay_window_en)
        else $error("cursor active under vertical scan");
    a_addr_16: assert property (@(posedge core_clk)
        disable iff (!rstn) size_sel == size_16x16 |-> glyph_address
            == glyph_ram_base + {11'h0, glyph_code, 5'h0})
        else $error("16x16 address wrong");
    a_full_code: assert property (@(posedge core_clk)
        disable iff (!rstn) glyph_code[15] |-> size_sel inside {
            size_16x16, size_24x24, size_32x32})
        else $error("full code used half size");
    a_half_code: assert property (@(posedge core_clk)
        disable iff (!rstn) !glyph_code[15] |-> !(size_sel inside {
            size_16x16, size_24x24, size_32x32}))
        else $error("half code used full size");
    a_transp_skip: assert property (@(posedge core_clk)
        disable iff (!rstn) pix_we && $past(attr[attr_transp]) |-> pix_fg)
        else $error("background written while transparent");
    a_fetch_wait: assert property (@(posedge core_clk)
        disable iff (!rstn) mem_req |=> state == st_wait)
        else $error("fetch not followed by wait");
    a_nibble_drop: assert property (@(posedge core_clk)
        disable iff (!rstn) state == st_wait && mem_rvalid && byte_idx[0]
            && size_sel == size_12x24 |=> cur_byte[3:0] == 4'h0)
        else $error("odd byte low nibble kept");
    a_addr_48: assert property (@(posedge core_clk)
        disable iff (!rstn) size_sel == size_12x24 |-> glyph_address
            == glyph_ram_base + {11'h0, glyph_code, 5'h0}
            + {12'h0, glyph_code, 4'h0})
        else $error("12x24 address wrong");
    c_render: cover property (@(posedge core_clk) state == st_pix && glyph_done);
    c_rotate: cover property (@(posedge core_clk) pix_we && attr[attr_rotate]);
    c_enlarge: cover property (@(posedge core_clk) pix_we && sx == 2'd3);
endmodule
`default_nettype wire

// file: verif/tb_top.sv
/*
 * self-checking bench for the glyph text attribute block: axi4-lite
 * register tasks, a one-cycle glyph byte memory, a pixel monitor.
 * assumes the block sits alone, clocked by core_clk at 20 mhz.
 */
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
    miscompares++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module tb_top;
    import glyph_pkg::*;
    logic        core_clk = 1'b0, rstn = 1'b0;
    logic [9:0]  s_awaddr = 10'h000, s_araddr = 10'h000;
    logic [7:0]  mem_rdata = 8'h00;
    logic [31:0] s_wdata = 32'h0, s_rdata, mem_addr;
    logic [3:0]  s_wstrb = 4'h0;
    logic        s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
    logic        s_arvalid = 1'b0, s_rready = 1'b0, mem_rvalid = 1'b0;
    logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic [1:0]  s_bresp, s_rresp;
    logic        mem_req, pix_fg, pix_we, req_s = 1'b0, corner;
    logic [15:0] pix_x, pix_y;
    logic        text_cursor_en, graphic_cursor_en, overlay_window_en;
    logic [31:0] exp_addr = 32'h0, nreq, npix, nfg, xmin, xmax, ymin, ymax;
    logic [31:0] d, exp_off, base_v = 32'h0000_1000;
    int          bpr = 1, hrep = 1;  // bytes per row, height repeats
    logic [1:0]  r;
    int miscompares = 0, check_count = 0, cycles = 0;
    // glyph geometry per size code: width, height, bytes, test code
    int gw[6] = '{8, 16, 12, 24, 16, 32};
    int gh[6] = '{16, 16, 24, 24, 32, 32};
    int nb[6] = '{16, 32, 48, 72, 64, 128};
    logic [15:0] cd[6] = '{16'h7fff, 16'h8000, 16'h0001, 16'hffff,
                           16'h0002, 16'h8003};
    logic [7:0] sc[4] = '{8'h01, 8'h04, 8'h0b, 8'h0f};

    glyph_text_attr u_glyph_text_attr (.*);

    // free-running clock, 50 ns period
    always #25 core_clk = ~core_clk;

    // hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 80000) begin
            miscompares++;
            finish_test;
        end
    end

    // byte memory: sample request mid-cycle, answer one cycle later
    always @(negedge core_clk) begin
        req_s = mem_req;
        if (mem_req === 1'b1) begin
            // each row is fetched again for every height repeat
            exp_off = nreq / (bpr * hrep) * bpr + nreq % bpr;
            `CHK("byte addr", exp_addr + exp_off, mem_addr)
            nreq++;
        end
        if (pix_we === 1'b1) begin
            npix++;
            nfg += {31'h0, pix_fg};
            if (pix_x == 16'd100 && pix_y == 16'd50) corner = pix_fg;
            if (pix_x < xmin) xmin = {16'h0, pix_x};
            if (pix_x > xmax) xmax = {16'h0, pix_x};
            if (pix_y < ymin) ymin = {16'h0, pix_y};
            if (pix_y > ymax) ymax = {16'h0, pix_y};
        end
    end
    // even bytes f0, odd bytes 0f
    always @(posedge core_clk) begin
        mem_rvalid <= req_s;
        mem_rdata  <= mem_addr[0] ? 8'h0f : 8'hf0;
    end

    task automatic axi_write(input logic [9:0] a, input logic [31:0] wd,
                             input logic [3:0] st, output logic [1:0] rs);
        logic ha, hw, hb;
        @(posedge core_clk);
        s_awaddr <= a; s_awvalid <= 1'b1; s_wdata <= wd;
        s_wstrb <= st; s_wvalid <= 1'b1; s_bready <= 1'b1;
        hb = 1'b0;
        while (!hb) begin
            @(negedge core_clk);
            ha = s_awvalid && s_awready;
            hw = s_wvalid && s_wready;
            hb = s_bvalid && s_bready;
            rs = s_bresp;
            @(posedge core_clk);
            if (ha) s_awvalid <= 1'b0;
            if (hw) s_wvalid <= 1'b0;
            if (hb) s_bready <= 1'b0;
        end
    endtask

    task automatic axi_read(input logic [9:0] a, output logic [31:0] rd,
                            output logic [1:0] rs);
        logic ha, hr;
        @(posedge core_clk);
        s_araddr <= a; s_arvalid <= 1'b1; s_rready <= 1'b1;
        hr = 1'b0;
        while (!hr) begin
            @(negedge core_clk);
            ha = s_arvalid && s_arready;
            hr = s_rvalid && s_rready;
            rd = s_rdata;
            rs = s_rresp;
            @(posedge core_clk);
            if (ha) s_arvalid <= 1'b0;
            if (hr) s_rready <= 1'b0;
        end
    endtask

    // one glyph: program, start, wait idle, check fetch and pixels
    task automatic render(input int sz, input logic [15:0] code,
                          input logic [7:0] at);
        int wf, hf, sf, fg;
        wf = at[1:0] + 1;
        hf = at[3:2] + 1;
        sf = wf * hf;
        fg = (sz == 2) ? 96 : nb[sz] * 4;
        axi_write(off_base, base_v, 4'hf, r);
        axi_write(off_code, {16'h0, code}, 4'h3, r);
        axi_write(off_attr, {24'h0, at}, 4'h1, r);
        axi_write(off_pos, {16'd50, 16'd100}, 4'hf, r);
        exp_addr = base_v + 32'(code) * 32'(nb[sz]);
        bpr = (gw[sz] + 7) / 8;
        hrep = hf;
        nreq = 0; npix = 0; nfg = 0; corner = 1'bx;
        xmin = '1; ymin = '1; xmax = 0; ymax = 0;
        axi_write(off_ctrl, 32'h100 | 32'(sz), 4'hf, r);
        d = 32'h1;
        while (d[0] !== 1'b0) axi_read(off_status, d, r);
        `CHK("bytes", nb[sz] * hf, nreq)
        `CHK("status addr", {exp_addr[30:0], 1'b0}, d)
        `CHK("fg pixels", fg * sf, nfg)
        `CHK("pixels", at[6] ? fg*sf : gw[sz]*gh[sz]*sf, npix)
        if (!at[6]) begin
            `CHK("corner", 1'b1, corner)
            `CHK("x0", 100, xmin)
            `CHK("y0", 50, ymin)
            `CHK("x span", at[4] ? gh[sz] : gw[sz]*wf, xmax-xmin+1)
            `CHK("y span", at[4] ? gw[sz] : gh[sz]*hf, ymax-ymin+1)
        end
    endtask

    task automatic finish_test;
        if (miscompares == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (6) @(posedge core_clk);
        rstn <= 1'b1;
        axi_read(off_attr, d, r);
        `CHK("attr reset", attr_reset, d[7:0])
        axi_read(off_base, d, r);
        `CHK("base reset", base_reset, d)
        axi_read(10'h020, d, r);
        `CHK("bad rd resp", 2'h2, r)
        `CHK("bad rd data", 32'h0, d)
        axi_write(10'h020, 32'h5a, 4'hf, r);
        `CHK("bad wr resp", 2'h2, r)
        for (int i = 0; i < 6; i++) render(i, cd[i], 8'h00);
        for (int i = 0; i < 4; i++) render(0, 16'h0010, sc[i]);
        render(1, 16'h8004, 8'h40);
        render(2, 16'h0005, 8'h41);
        render(2, 16'h0006, 8'h10);
        render(0, 16'h0001, 8'h00);
        axi_read(off_pos, d, r);
        `CHK("pen plain", 16'd108, d[15:0])
        render(0, 16'h0001, 8'h80);
        axi_read(off_pos, d, r);
        `CHK("pen align", 16'd116, d[15:0])
        axi_write(off_ctrl, 32'h8, 4'hf, r);
        `CHK("vertical_scan_direction en", 3'b000, {text_cursor_en, graphic_cursor_en,
                                 overlay_window_en})
        axi_write(off_ctrl, 32'h0, 4'hf, r);
        `CHK("vertical_scan_direction off", 3'b111, {text_cursor_en, graphic_cursor_en,
                                  overlay_window_en})
        finish_test;
    end
endmodule
`default_nettype wire
